// ===== rtl/ebpwm_consts.svh
// Register offsets, field positions, reset values and timing counts of the PWM timer.
`ifndef EBPWM_CONSTS_SVH
`define EBPWM_CONSTS_SVH
// ---------------------------------------------------------------------------
// Register byte offsets.
// ---------------------------------------------------------------------------
`define EBPWM_OFF_MODE    12'h000
`define EBPWM_OFF_PERIOD  12'h004
`define EBPWM_OFF_DUTY    12'h008
`define EBPWM_OFF_STATUS  12'h00C
`define EBPWM_OFF_MASK    12'h010
`define EBPWM_OFF_PORT    12'h014
// ---------------------------------------------------------------------------
// Field positions in the mode register.
// ---------------------------------------------------------------------------
`define EBPWM_BIT_RUN     0
`define EBPWM_BIT_LEVEL   1
`define EBPWM_BIT_OE      2
`define EBPWM_BIT_CKS     4
`define EBPWM_CKS_W       3
// ---------------------------------------------------------------------------
// Field positions in the port register.
// ---------------------------------------------------------------------------
`define EBPWM_BIT_LATCH_A 0
`define EBPWM_BIT_MODE_A  1
`define EBPWM_BIT_LATCH_B 2
`define EBPWM_BIT_MODE_B  3
// ---------------------------------------------------------------------------
// Reset values and timing.
// ---------------------------------------------------------------------------
`define EBPWM_RST_MODE    8'h00
`define EBPWM_RST_PERIOD  8'hFF
`define EBPWM_RST_DUTY    8'h00
`define EBPWM_RST_PORT    4'hF
`define EBPWM_DUTY_DELAY  3
`endif

// ===== rtl/ebpwm_pkg.sv
// Types shared by the PWM timer modules.
package ebpwm_pkg;
   // Delivery state of a freshly written duty value.
   typedef enum logic [1:0] {
      EBPWM_DUTY_IDLE = 2'b00,
      EBPWM_DUTY_WAIT = 2'b01
   } ebpwm_duty_state_type;
endpackage : ebpwm_pkg

// ===== rtl/ebpwm_prescaler.sv
// Count clock prescaler producing a one-cycle tick at the selected rate.
`timescale 1ns/1ps
module ebpwm_prescaler
   import ebpwm_pkg::*;
#(
   parameter int DIV_W = 12
) (
   // Clock and reset.
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Control.
   input  wire logic [2:0] sel,
   // Tick out.
   output logic            tick
);
   // A narrower divider cannot reach the slowest count clock, so refuse it.
   if (DIV_W < 12) begin : g_bad_div
      $error("DIV_W must be at least 12");
   end

   logic [DIV_W-1:0] div_q;   // Free-running divider.
   logic [DIV_W-1:0] div_d;   // Next divider value.
   logic [DIV_W-1:0] wrap;    // Mask of low bits that must all be one.

   assign div_d = div_q + {{(DIV_W-1){1'b0}}, 1'b1};
   // Divide ratios 1, 2, 4, 16, 64, 256, 1024, 4096.
   assign wrap = (sel == 3'h0) ? '0 :
                 (sel == 3'h1) ? DIV_W'(12'h001) :
                 (sel == 3'h2) ? DIV_W'(12'h003) :
                 (sel == 3'h3) ? DIV_W'(12'h00F) :
                 (sel == 3'h4) ? DIV_W'(12'h03F) :
                 (sel == 3'h5) ? DIV_W'(12'h0FF) :
                 (sel == 3'h6) ? DIV_W'(12'h3FF) : DIV_W'(12'hFFF);
   // A tick is issued when all masked low bits are ones.
   assign tick = ((div_q & wrap) == wrap);

   // ------------------------------------------------------------------------
   // Divider register.
   // ------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= '0;
      end else begin
         div_q <= div_d;
      end
   end
endmodule : ebpwm_prescaler

// ===== rtl/ebpwm_timer.sv
// Eight-bit PWM timer channel with an APB register slave.
//
// Contract
// R1 - Writing run bit one starts counting.
// R2 - Writing run bit zero stops counting.
// R3 - Software never rewrites period while running.
// R4 - Software keeps duty below period, 8-bit.
// R5 - Output disabled holds pin low.
// R6 - Latch one holds disabled pin high.
// R7 - Start level follows level select bit.
// R8 - Pin inverts on counter-period match.
// R9 - Software zeroes port mode and latch.
// R10 - Period is count clock times period+1.
// R11 - High width set by duty and level.
// R12 - Interrupt on tick after period match.
// R13 - Duty reaches compare three clocks late.
// R14 - Counter counts up, wraps to zero.
// R15 - Counter value is never readable.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "ebpwm_consts.svh"
module ebpwm_timer
   import ebpwm_pkg::*;
#(
   parameter int DIV_W = 12
) (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Timer output pin and interrupt.
   output logic             pwm_output_pin,
   output logic             pwm_output_pin_oe,
   output logic             compare_irq
);
   // ------------------------------------------------------------------------
   // Register state.
   // ------------------------------------------------------------------------
   logic [7:0]  timer_mode_reg_q;      // Run, level, enable, clock select.
   logic [7:0]  period_compare_q;      // Period compare value.
   logic [7:0]  duty_compare_q;        // Software-visible duty value.
   logic [7:0]  duty_active_q;         // Duty value used by the comparator.
   logic [1:0]  duty_cnt_q;            // Operating clocks since duty write.
   ebpwm_duty_state_type duty_st_q;    // Duty transfer state.
   logic [3:0]  port_q;                // Port latch and mode bits.
   logic        status_q;              // Sticky compare event.
   logic        mask_q;                // Interrupt enable for the event.
   logic [7:0]  count_q;               // Up-counter, never readable.
   logic        level_q;               // Waveform level.
   logic        run_q;                 // Run bit delayed, for start detect.
   logic [31:0] prdata_q;              // Registered read data.
   logic        pend_q;                // Period match seen, waiting for tick.

   // ------------------------------------------------------------------------
   // Bus decode.
   // ------------------------------------------------------------------------
   wire        access    = psel && penable;
   wire        wr        = access && pwrite && pstrb[0];
   wire        rd_setup  = psel && !penable && !pwrite;
   wire        hit_mode  = (paddr == `EBPWM_OFF_MODE);
   wire        hit_per   = (paddr == `EBPWM_OFF_PERIOD);
   wire        hit_duty  = (paddr == `EBPWM_OFF_DUTY);
   wire        hit_stat  = (paddr == `EBPWM_OFF_STATUS);
   wire        hit_mask  = (paddr == `EBPWM_OFF_MASK);
   wire        hit_port  = (paddr == `EBPWM_OFF_PORT);
   wire        mapped    = hit_mode | hit_per | hit_duty | hit_stat | hit_mask | hit_port;
   wire        run       = timer_mode_reg_q[`EBPWM_BIT_RUN];
   wire        lvl_sel   = timer_mode_reg_q[`EBPWM_BIT_LEVEL];
   wire        oe_bit    = timer_mode_reg_q[`EBPWM_BIT_OE];
   wire [2:0]  cks       = timer_mode_reg_q[`EBPWM_BIT_CKS +: `EBPWM_CKS_W];
   wire        tick;
   wire        per_match = (count_q == period_compare_q);
   wire        duty_match = (count_q == duty_active_q);
   wire        start     = run && !run_q;
   wire        event_set = run && tick && pend_q;
   wire        latch_a   = port_q[`EBPWM_BIT_LATCH_A];
   wire [31:0] rd_mux;

   // The counter is deliberately absent from the read mux.  // see R15
   assign rd_mux = hit_mode ? {24'h000000, timer_mode_reg_q} :
                   hit_per  ? {24'h000000, period_compare_q} :
                   hit_duty ? {24'h000000, duty_compare_q} :
                   hit_stat ? {31'h00000000, status_q} :
                   hit_mask ? {31'h00000000, mask_q} :
                   hit_port ? {28'h0000000, port_q} : 32'h00000000;

   // The slave answers without wait states; unmapped addresses error.
   assign pready  = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata  = prdata_q;

   // ------------------------------------------------------------------------
   // Count clock prescaler.
   // ------------------------------------------------------------------------
   ebpwm_prescaler #(
      .DIV_W (DIV_W)
   ) u_presc (
      .pclk    (pclk),
      .presetn (presetn),
      .sel     (cks),
      .tick    (tick)
   );

   // Read data is captured in the setup phase so it is stable in access.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
      end else if (rd_setup) begin
         prdata_q <= rd_mux;
      end
   end

   // ------------------------------------------------------------------------
   // Software registers.
   // ------------------------------------------------------------------------
   // Period writes during running are ignored as a guard.  // see R3
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_mode_reg_q <= `EBPWM_RST_MODE;
         period_compare_q <= `EBPWM_RST_PERIOD;
         duty_compare_q   <= `EBPWM_RST_DUTY;
         port_q           <= `EBPWM_RST_PORT;
         mask_q           <= 1'b0;
      end else if (wr) begin
         if (hit_mode) begin
            timer_mode_reg_q <= pwdata[7:0];     // see R1 see R2
         end
         if (hit_per && !run) begin
            period_compare_q <= pwdata[7:0];
         end
         if (hit_duty) begin
            duty_compare_q <= pwdata[7:0];
         end
         if (hit_port) begin
            port_q <= pwdata[3:0];
         end
         if (hit_mask) begin
            mask_q <= pwdata[0];
         end
      end
   end

   // Sticky status; a new event wins over a write-one clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= 1'b0;
      end else if (event_set) begin
         status_q <= 1'b1;                       // see R12
      end else if (wr && hit_stat && pwdata[0]) begin
         status_q <= 1'b0;
      end
   end

   assign compare_irq = status_q && mask_q;

   // ------------------------------------------------------------------------
   // Duty transfer: three operating clocks from write to comparator.
   // ------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_st_q     <= EBPWM_DUTY_IDLE;
         duty_cnt_q    <= 2'h0;
         duty_active_q <= `EBPWM_RST_DUTY;
      end else if (wr && hit_duty) begin
         duty_st_q  <= EBPWM_DUTY_WAIT;
         duty_cnt_q <= 2'h0;
      end else begin
         unique case (duty_st_q)
            EBPWM_DUTY_IDLE: begin
               duty_cnt_q <= 2'h0;
            end
            EBPWM_DUTY_WAIT: begin
               if (tick) begin
                  if (duty_cnt_q == 2'(`EBPWM_DUTY_DELAY - 1)) begin
                     duty_active_q <= duty_compare_q;   // see R13
                     duty_st_q     <= EBPWM_DUTY_IDLE;
                  end else begin
                     duty_cnt_q <= duty_cnt_q + 2'h1;
                  end
               end
            end
            default: begin
               duty_st_q <= EBPWM_DUTY_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // Counter and waveform.
   // ------------------------------------------------------------------------
   // The counter runs 0..period, so one PWM cycle is period+1 ticks.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= 8'h00;
         pend_q  <= 1'b0;
         run_q   <= 1'b0;
         level_q <= 1'b0;
      end else begin
         run_q <= run;
         if (!run) begin
            count_q <= 8'h00;
            pend_q  <= 1'b0;
            level_q <= lvl_sel;                  // see R7
         end else if (start) begin
            count_q <= 8'h00;
            level_q <= lvl_sel;                  // see R7
         end else if (tick) begin
            pend_q <= per_match;
            // Levels are set, not toggled: a blind toggle would flip the phase
            // in the first cycle after start or when a new duty lands mid-cycle.
            if (per_match) begin
               count_q <= 8'h00;                 // see R14 see R10
               level_q <= ~lvl_sel;              // see R8
            end else begin
               count_q <= count_q + 8'h01;       // see R14
               if (duty_match) begin
                  level_q <= lvl_sel;            // see R11
               end
            end
         end
      end
   end

   // Disabled output reads low, or high through the port latch.
   // The waveform only shows while the shared pin's mode and latch are zero.
   assign pwm_output_pin    = oe_bit ? (level_q && (port_q == 4'h0)) : latch_a;  // see R5 see R6
   assign pwm_output_pin_oe = 1'b1;
endmodule : ebpwm_timer

// ===== tb/ebpwm_timer_sva.sv
// Port-level checker of the PWM timer channel.
`timescale 1ns/1ps
`include "ebpwm_consts.svh"
module ebpwm_timer_sva
   import ebpwm_pkg::*;
#(
   parameter int DIV_W = 12
) (
   // Clock and reset.
   input wire logic        pclk,
   input wire logic        presetn,
   // APB side.
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Pin and interrupt.
   input wire logic        pwm_output_pin,
   input wire logic        pwm_output_pin_oe,
   input wire logic        compare_irq
);
   // -----------------------------------------------------------------
   // Shadow registers, rebuilt from the bus traffic alone.
   // -----------------------------------------------------------------
   wire       wr     = psel && penable && pwrite && pstrb[0];
   wire       mapped = (paddr[1:0] == 2'h0) && (paddr <= `EBPWM_OFF_PORT);
   logic [6:0] mode_q;  // Run, level, enable and clock select.
   logic [7:0] per_q;   // Period as it should read back.
   logic       mask_q;  // Interrupt mask.
   logic [3:0] port_q;  // Shared pin latch and mode bits.
   // The period copy ignores writes while running, so a refused write shows up.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= 7'h00;
         per_q  <= `EBPWM_RST_PERIOD;
         mask_q <= 1'b0;
         port_q <= `EBPWM_RST_PORT;
      end else if (wr) begin
         if (paddr == `EBPWM_OFF_MODE) mode_q <= pwdata[6:0];
         if (paddr == `EBPWM_OFF_PERIOD && !mode_q[0]) per_q <= pwdata[7:0];
         if (paddr == `EBPWM_OFF_MASK) mask_q <= pwdata[0];
         if (paddr == `EBPWM_OFF_PORT) port_q <= pwdata[3:0];
      end
   end
   // -----------------------------------------------------------------
   // Properties.
   // -----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_read;
      psel && penable && !pwrite;
   endsequence
   a_ready_high: assert property (pready && pwm_output_pin_oe) else $error("ready or oe low");
   a_err_decode: assert property (psel && penable |-> pslverr == !mapped) else $error("bad err");
   a_err_read_zero: assert property (s_read ##0 !mapped |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_period_kept: assert property (s_read ##0 paddr == `EBPWM_OFF_PERIOD
      |-> prdata == {24'h0, per_q}) else $error("period readback wrong");
   a_off_low: assert property (!mode_q[2] && !port_q[0] |-> !pwm_output_pin)
      else $error("disabled pin not low");
   a_off_latch_high: assert property (!mode_q[2] && port_q[0] |-> pwm_output_pin)
      else $error("latched pin not high");
   a_idle_level: assert property (!mode_q[0] && $stable(mode_q) && mode_q[2]
      && port_q == 4'h0 |-> pwm_output_pin == mode_q[1]) else $error("idle level wrong");
   a_irq_masked: assert property (!mask_q |-> !compare_irq) else $error("masked irq high");
   a_irq_sticky: assert property (compare_irq && !(wr && paddr >= `EBPWM_OFF_STATUS)
      |=> compare_irq) else $error("irq dropped");
endmodule : ebpwm_timer_sva

bind ebpwm_timer ebpwm_timer_sva #(.DIV_W(DIV_W)) u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pwm_output_pin(pwm_output_pin), .pwm_output_pin_oe(pwm_output_pin_oe),
   .compare_irq(compare_irq));

// ===== tb/testbench.sv
// Self-checking bench of the PWM timer channel.
`timescale 1ns/1ps
`include "ebpwm_consts.svh"
module testbench
   import ebpwm_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        pwm_output_pin, pwm_output_pin_oe, compare_irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   int          n_fail, checked;
   // Reset values, and one unmapped place at the end.
   localparam logic [11:0] RA [7] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014,
                                       12'h018};
   localparam logic [31:0] RV [7] = '{32'h0, 32'hFF, 32'h0, 32'h0, 32'h0, 32'hF, 32'h0};
   ebpwm_timer #(.DIV_W(12)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_output_pin(pwm_output_pin),
      .pwm_output_pin_oe(pwm_output_pin_oe), .compare_irq(compare_irq));
   always #4 pclk = ~pclk;
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // One APB transfer; the request holds until pready is seen at an edge.
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r, output logic err);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(a, 1'b1, d, r, e);
   endtask : wr
   // Counts the high and low spans of one whole cycle of the pin.
   task automatic meas(output int hi, output int lo);
      int n;
      hi = 0; lo = 0; n = 0;
      while (pwm_output_pin !== 1'b0 && n < 900) begin @(negedge pclk); n++; end
      while (pwm_output_pin !== 1'b1 && n < 900) begin @(negedge pclk); n++; end
      while (pwm_output_pin === 1'b1 && n < 900) begin @(negedge pclk); hi++; n++; end
      while (pwm_output_pin === 1'b0 && n < 900) begin @(negedge pclk); lo++; n++; end
   endtask : meas
   task automatic t_reset;
      logic [31:0] r;
      logic        e;
      chk(pwm_output_pin, 1'b1);
      for (int i = 0; i < 7; i++) begin
         apb(RA[i], 1'b0, 32'h0, r, e);
         chk(r, RV[i]);
         chk(e, i == 6);
      end
   endtask : t_reset
   task automatic t_outen;
      wr(12'h014, 32'h0);
      @(negedge pclk);
      chk(pwm_output_pin, 1'b0);
      wr(12'h014, 32'h1);
      @(negedge pclk);
      chk(pwm_output_pin, 1'b1);
   endtask : t_outen
   // Period 7, duty 2 then 4, at the fastest count clock.
   task automatic t_pwm(input logic lv);
      logic [31:0] r;
      logic        e;
      int          hi, lo;
      wr(12'h014, 32'h0);
      wr(12'h004, 32'h7);
      wr(12'h008, 32'h2);
      wr(12'h000, 32'h4 | (lv << 1));
      repeat (2) @(negedge pclk);
      chk(pwm_output_pin, lv);
      wr(12'h000, 32'h5 | (lv << 1));
      meas(hi, lo);
      meas(hi, lo);
      chk(hi, lv ? 5 : 3);
      chk(hi + lo, 8);
      wr(12'h004, 32'h3);
      apb(12'h004, 1'b0, 32'h0, r, e);
      chk(r, 32'h7);
      wr(12'h008, 32'h4);
      meas(hi, lo);
      meas(hi, lo);
      chk(hi, lv ? 3 : 5);
      chk(hi + lo, 8);
      wr(12'h000, 32'h4 | (lv << 1));
      repeat (3) @(negedge pclk);
      for (int i = 0; i < 20; i++) begin
         @(negedge pclk);
         chk(pwm_output_pin, lv);
      end
   endtask : t_pwm
   // Register writes land at the access edge, so compare_irq is looked at a half cycle later.
   task automatic t_irq;
      int n;
      wr(12'h010, 32'h1);
      wr(12'h00C, 32'h1);
      @(negedge pclk);
      chk(compare_irq, 1'b0);
      wr(12'h000, 32'h5);
      n = 0;
      while (compare_irq !== 1'b1 && n < 40) begin @(negedge pclk); n++; end
      chk(compare_irq, 1'b1);
      // Write edge, start edge, eight ticks to the period match, one more tick to the flag.
      chk(n, 11);
      wr(12'h010, 32'h0);
      @(negedge pclk);
      chk(compare_irq, 1'b0);
      wr(12'h000, 32'h4);
      wr(12'h010, 32'h1);
      @(negedge pclk);
      chk(compare_irq, 1'b1);
      wr(12'h00C, 32'h1);
      @(negedge pclk);
      chk(compare_irq, 1'b0);
   endtask : t_irq
   task automatic report_and_stop;
      if (n_fail == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   initial begin
      #200000;
      n_fail++;
      report_and_stop;
   end
   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
      paddr = 0; pwdata = 0; pstrb = 4'hF; n_fail = 0; checked = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_outen;
      t_pwm(1'b0);
      t_pwm(1'b1);
      t_irq;
      report_and_stop;
   end
endmodule : testbench
